// [tvi_defines.vh]
// Register indices, field positions, reset values and vector constants of the interrupt unit
`ifndef TVI_DEFINES_VH
`define TVI_DEFINES_VH

// Register indices; byte address on the bus is index times four
`define TVI_IDX_TIMER_CTL 8'h88
`define TVI_IDX_INT_EN 8'ha8
`define TVI_IDX_INT_PRI 8'hb8
`define TVI_IDX_EXT_EN1 8'he6
`define TVI_IDX_EXT_EN2 8'he7
`define TVI_IDX_EXT_PRI1 8'hf6
`define TVI_IDX_EXT_PRI2 8'hf7
`define TVI_IDX_SECOND_OP 8'hf0
`define TVI_IDX_PEND_A 8'hc0
`define TVI_IDX_PEND_B 8'hc1
`define TVI_IDX_PEND_C 8'hc2
`define TVI_IDX_STATUS 8'hc3

// Timer control register fields
`define TVI_TC_EXT0_TRIG 0
`define TVI_TC_EXT0_PEND 1
`define TVI_TC_EXT1_TRIG 2
`define TVI_TC_EXT1_PEND 3
`define TVI_TC_TMR0_RUN 4
`define TVI_TC_TMR0_OVF 5
`define TVI_TC_TMR1_RUN 6
`define TVI_TC_TMR1_OVF 7

// Enable register global bit
`define TVI_GLOBAL_EN_BIT 7

// Reset value, priority read-back ones and extended enable 1 read mask
`define TVI_RST_BYTE 8'h00
`define TVI_PRI_RD_ONES 8'hc0
`define TVI_EXT_EN1_RD_MASK 8'h7f

// Source ranks (lower rank wins)
`define TVI_NUM_RANK 21
`define TVI_RANK_EXT0 0
`define TVI_RANK_TMR0 1
`define TVI_RANK_EXT1 2
`define TVI_RANK_TMR1 3
`define TVI_RANK_UNUSED 13
`define TVI_RANK_CAN 19

// Vectors: reset, first source, eight-byte spacing as a shift
`define TVI_RESET_VECTOR 16'h0000
`define TVI_VECTOR_BASE 16'h0003
`define TVI_VECTOR_SHIFT 3

`endif

// [tvi_unit.v]
// Two-level vectored interrupt unit with Wishbone register access
// Overview of operation
// - Twenty sources, each low or high level.
// - Pending flag sets regardless of any enable.
// - Enabled pending flag raises vectored call request.
// - Disabled pending flag produces no request.
// - Global enable bit gates every source enable.
// - Per-source enable and priority bits in registers.
// - Return resumes the interrupted instruction stream.
// - Hardware clears only edge-ext, timer, CAN flags.
// - Flag still set after return re-requests later.
// - Software writing one acts as real event.
// - Global clear race may admit request; reads zero.
// - Clear then multi-cycle instruction blocks request.
// - External pins active low; trigger select chooses.
// - External pending flags at timer control bits.
// - Edge mode latches falling edge, cleared vectoring.
// - Level mode flag follows the pin directly.
// - Reset 0x0000, sources from 0x0003, eight apart.
// - Fixed ranks 0 to 20, reset above.
// - Eight-bit second operand register, resets zero.
// - High preempts low; equal level by rank.
// - Decode every clock; detect takes one clock.
//
// Chosen here: register access over Wishbone.
`timescale 1ns/100ps
`include "tvi_defines.vh"

module tvi_unit
(
	input wire clk, // System clock, 125 MHz
	input wire rst_b, // Asynchronous reset, active low
	input wire wb_cyc_i, // Wishbone cycle
	input wire wb_stb_i, // Wishbone strobe
	input wire wb_we_i, // Wishbone write enable
	input wire [9:0] wb_adr_i, // Wishbone byte address
	input wire [3:0] wb_sel_i, // Wishbone byte selects
	input wire [31:0] wb_dat_i, // Wishbone write data
	output reg [31:0] wb_dat_o, // Wishbone read data
	output reg wb_ack_o, // Wishbone acknowledge
	input wire ext_irq0_pin, // External interrupt 0, active low
	input wire ext_irq1_pin, // External interrupt 1, active low
	input wire [20:0] src_event, // Peripheral event pulses by rank
	input wire cpu_instr_done, // Pulse: CPU finished an instruction
	input wire cpu_take, // Pulse: CPU starts the long call
	input wire cpu_return_from_interrupt, // Pulse: return from interrupt completed
	output reg int_req, // Request to the CPU sequencer
	output reg [4:0] int_src, // Rank of the requesting source
	output reg [15:0] int_vector // Call address of that source
);

	// Register storage
	reg [7:0] timer_control_reg;
	reg [7:0] int_enable_reg;
	reg [5:0] int_priority_reg;
	reg [6:0] extended_enable_reg_1;
	reg [6:0] extended_enable_reg_2;
	reg [6:0] extended_priority_reg_1;
	reg [6:0] extended_priority_reg_2;
	reg [7:0] second_operand_register;
	reg [20:0] pend;
	reg ext0_prev;
	reg ext1_prev;
	reg svc_hi;
	reg svc_lo;
	reg return_from_interrupt_hold;

	// Combinational next values
	reg [20:0] sw_we;
	reg [20:0] sw_val;
	reg [20:0] hw_clr;
	reg [20:0] evt;
	reg [20:0] next_pend;
	reg next_req;
	reg [4:0] next_src;
	reg [7:0] rd_byte;

	wire [7:0] reg_idx;
	wire [7:0] wd;
	wire wr;
	wire take;
	wire ext0_edge_mode;
	wire ext1_edge_mode;
	wire ext0_fall;
	wire ext1_fall;
	wire [20:0] en_vec;
	wire [20:0] pri_vec;
	wire [20:0] elig;
	wire [20:0] hi_cand;
	wire [20:0] lo_cand;

	// Lowest set rank of a candidate vector; rank order decides among equals
	// Scans from the top so the lowest rank is written last and wins
	function [4:0] first_rank;
		input [20:0] v;
		integer i;
		begin
			first_rank = 5'h00;
			for (i = `TVI_NUM_RANK - 1; i >= 0; i = i - 1)
				if (v[i])
					first_rank = i[4:0];
		end
	endfunction

	assign reg_idx = wb_adr_i[9:2];
	assign wd = wb_dat_i[7:0];
	// Write lands on the edge where the master sees ack
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign take = cpu_take & int_req;

	// External pins are active low; trigger select 1 means edge
	assign ext0_edge_mode = timer_control_reg[`TVI_TC_EXT0_TRIG];
	assign ext1_edge_mode = timer_control_reg[`TVI_TC_EXT1_TRIG];
	assign ext0_fall = ext0_prev & ~ext_irq0_pin;
	assign ext1_fall = ext1_prev & ~ext_irq1_pin;

	// Per-source enables and levels, rank 13 has no source
	assign en_vec = int_enable_reg[`TVI_GLOBAL_EN_BIT] ?
		{extended_enable_reg_2, 1'b0, extended_enable_reg_1, int_enable_reg[5:0]} :
		21'h000000;
	assign pri_vec = {extended_priority_reg_2, 1'b0, extended_priority_reg_1,
		int_priority_reg};
	assign elig = pend & en_vec;
	assign hi_cand = elig & pri_vec;
	assign lo_cand = elig & ~pri_vec;

	// Software writes to pending flags, per source
	always @*
	begin
		sw_we = 21'h000000;
		sw_val = 21'h000000;
		if (wr && reg_idx == `TVI_IDX_TIMER_CTL)
		begin
			sw_we[`TVI_RANK_EXT0] = 1'b1;
			sw_we[`TVI_RANK_TMR0] = 1'b1;
			sw_we[`TVI_RANK_EXT1] = 1'b1;
			sw_we[`TVI_RANK_TMR1] = 1'b1;
			sw_val[`TVI_RANK_EXT0] = wd[`TVI_TC_EXT0_PEND];
			sw_val[`TVI_RANK_TMR0] = wd[`TVI_TC_TMR0_OVF];
			sw_val[`TVI_RANK_EXT1] = wd[`TVI_TC_EXT1_PEND];
			sw_val[`TVI_RANK_TMR1] = wd[`TVI_TC_TMR1_OVF];
		end
		else if (wr && reg_idx == `TVI_IDX_PEND_A)
		begin
			sw_we[11:4] = 8'hff;
			sw_val[11:4] = wd;
		end
		else if (wr && reg_idx == `TVI_IDX_PEND_B)
		begin
			sw_we[19:12] = 8'hff;
			sw_val[19:12] = wd;
		end
		else if (wr && reg_idx == `TVI_IDX_PEND_C)
		begin
			sw_we[20] = 1'b1;
			sw_val[20] = wd[0];
		end
	end

	// Hardware clear on vectoring, only for the self-clearing sources
	// Level-mode external flags follow the pin, so a clear there would be undone
	always @*
	begin
		hw_clr = 21'h000000;
		if (take)
		begin
			if (int_src == `TVI_RANK_EXT0 && ext0_edge_mode)
				hw_clr[`TVI_RANK_EXT0] = 1'b1;
			if (int_src == `TVI_RANK_EXT1 && ext1_edge_mode)
				hw_clr[`TVI_RANK_EXT1] = 1'b1;
			if (int_src == `TVI_RANK_TMR0)
				hw_clr[`TVI_RANK_TMR0] = 1'b1;
			if (int_src == `TVI_RANK_TMR1)
				hw_clr[`TVI_RANK_TMR1] = 1'b1;
			if (int_src == `TVI_RANK_CAN)
				hw_clr[`TVI_RANK_CAN] = 1'b1;
		end
	end

	// Pending flag update; a same-cycle event beats any clear
	always @*
	begin
		evt = src_event;
		evt[`TVI_RANK_EXT0] = ext0_edge_mode & ext0_fall;
		evt[`TVI_RANK_EXT1] = ext1_edge_mode & ext1_fall;
		evt[`TVI_RANK_UNUSED] = 1'b0;
		next_pend = (((sw_we & sw_val) | (~sw_we & pend)) & ~hw_clr) | evt;
		if (!ext0_edge_mode)
			next_pend[`TVI_RANK_EXT0] = ~ext_irq0_pin;
		if (!ext1_edge_mode)
			next_pend[`TVI_RANK_EXT1] = ~ext_irq1_pin;
		next_pend[`TVI_RANK_UNUSED] = 1'b0;
	end

	// Arbitration each clock: high level first, then low, rank breaks ties
	// A high routine in service blocks everything, a low one blocks only low
	always @*
	begin
		next_req = 1'b0;
		next_src = 5'h00;
		if (|hi_cand && !svc_hi)
		begin
			next_req = 1'b1;
			next_src = first_rank(hi_cand);
		end
		else if (|lo_cand && !svc_hi && !svc_lo)
		begin
			next_req = 1'b1;
			next_src = first_rank(lo_cand);
		end
		// After a return, one instruction runs before a new call
		if (return_from_interrupt_hold || cpu_return_from_interrupt)
			next_req = 1'b0;
		// The flag just vectored is not offered twice
		if (take)
			next_req = 1'b0;
	end

	// Pending flags and pin history
	// Pin history resets to the idle high level, so reset makes no false edge
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pend <= 21'h000000;
			ext0_prev <= 1'b1;
			ext1_prev <= 1'b1;
		end
		else
		begin
			pend <= next_pend;
			ext0_prev <= ext_irq0_pin;
			ext1_prev <= ext_irq1_pin;
		end
	end

	// Request register: one clock of detect before the CPU can call
	// A request registered while the global enable was still set can be
	// taken at a boundary in the next clock; later boundaries see it gone
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			int_req <= 1'b0;
			int_src <= 5'h00;
			int_vector <= `TVI_RESET_VECTOR;
		end
		else
		begin
			int_req <= next_req;
			int_src <= next_src;
			int_vector <= {8'h00, next_src, 3'b000} + `TVI_VECTOR_BASE;
		end
	end

	// In-service levels and post-return hold
	// A return closes the innermost routine: high first, since only high preempts
	// A return with nothing in service leaves both levels clear
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			svc_hi <= 1'b0;
			svc_lo <= 1'b0;
			return_from_interrupt_hold <= 1'b0;
		end
		else
		begin
			if (take && pri_vec[int_src])
				svc_hi <= 1'b1;
			else if (cpu_return_from_interrupt && svc_hi)
				svc_hi <= 1'b0;
			if (take && !pri_vec[int_src])
				svc_lo <= 1'b1;
			else if (cpu_return_from_interrupt && !svc_hi)
				svc_lo <= 1'b0;
			if (cpu_return_from_interrupt)
				return_from_interrupt_hold <= 1'b1;
			else if (cpu_instr_done)
				return_from_interrupt_hold <= 1'b0;
		end
	end

	// Software registers; pending bits live in pend above
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			timer_control_reg <= `TVI_RST_BYTE;
			int_enable_reg <= `TVI_RST_BYTE;
			int_priority_reg <= 6'h00;
			extended_enable_reg_1 <= 7'h00;
			extended_enable_reg_2 <= 7'h00;
			extended_priority_reg_1 <= 7'h00;
			extended_priority_reg_2 <= 7'h00;
			second_operand_register <= `TVI_RST_BYTE;
		end
		else if (wr)
		begin
			if (reg_idx == `TVI_IDX_TIMER_CTL)
				timer_control_reg <= wd;
			else if (reg_idx == `TVI_IDX_INT_EN)
				int_enable_reg <= wd;
			else if (reg_idx == `TVI_IDX_INT_PRI)
				int_priority_reg <= wd[5:0];
			else if (reg_idx == `TVI_IDX_EXT_EN1)
				extended_enable_reg_1 <= wd[6:0];
			else if (reg_idx == `TVI_IDX_EXT_EN2)
				extended_enable_reg_2 <= wd[6:0];
			else if (reg_idx == `TVI_IDX_EXT_PRI1)
				extended_priority_reg_1 <= wd[6:0];
			else if (reg_idx == `TVI_IDX_EXT_PRI2)
				extended_priority_reg_2 <= wd[6:0];
			else if (reg_idx == `TVI_IDX_SECOND_OP)
				second_operand_register <= wd;
		end
	end

	// Read decode; unmapped indices read zero
	always @*
	begin
		rd_byte = 8'h00;
		if (reg_idx == `TVI_IDX_TIMER_CTL)
			rd_byte = {pend[`TVI_RANK_TMR1], timer_control_reg[`TVI_TC_TMR1_RUN],
				pend[`TVI_RANK_TMR0], timer_control_reg[`TVI_TC_TMR0_RUN],
				pend[`TVI_RANK_EXT1], timer_control_reg[`TVI_TC_EXT1_TRIG],
				pend[`TVI_RANK_EXT0], timer_control_reg[`TVI_TC_EXT0_TRIG]};
		else if (reg_idx == `TVI_IDX_INT_EN)
			rd_byte = int_enable_reg;
		else if (reg_idx == `TVI_IDX_INT_PRI)
			rd_byte = `TVI_PRI_RD_ONES | {2'b00, int_priority_reg};
		else if (reg_idx == `TVI_IDX_EXT_EN1)
			rd_byte = `TVI_EXT_EN1_RD_MASK & {1'b0, extended_enable_reg_1};
		else if (reg_idx == `TVI_IDX_EXT_EN2)
			rd_byte = {1'b0, extended_enable_reg_2};
		else if (reg_idx == `TVI_IDX_EXT_PRI1)
			rd_byte = {1'b0, extended_priority_reg_1};
		else if (reg_idx == `TVI_IDX_EXT_PRI2)
			rd_byte = {1'b0, extended_priority_reg_2};
		else if (reg_idx == `TVI_IDX_SECOND_OP)
			rd_byte = second_operand_register;
		else if (reg_idx == `TVI_IDX_PEND_A)
			rd_byte = pend[11:4];
		else if (reg_idx == `TVI_IDX_PEND_B)
			rd_byte = pend[19:12];
		else if (reg_idx == `TVI_IDX_PEND_C)
			rd_byte = {7'h00, pend[20]};
		else if (reg_idx == `TVI_IDX_STATUS)
			rd_byte = {svc_hi, svc_lo, int_req, int_src};
	end

	// Bus slave: ack one clock after the request, dropped the clock after
	// Ack gates its own next value, so a held strobe is never answered on two clocks in a row
	// Read data is captured at the request edge, so it stands with ack
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o)
				wb_dat_o <= {24'h000000, rd_byte};
		end
	end

endmodule // tvi_unit

// [tvi_cpu_model.sv]
// CPU sequencer stand-in that ends instructions and makes the long call
`timescale 1ns/100ps
module tvi_cpu_model
(
	input wire clk, // System clock
	input wire rst_b, // Reset, active low
	input wire slow, // Instructions last four clocks instead of one
	input wire int_req, // Request from the unit
	input wire [15:0] int_vector, // Call address
	output reg cpu_instr_done, // Instruction completed
	output reg cpu_take, // Long call started
	output reg [15:0] last_vec, // Address of the last call
	output reg [7:0] takes // Calls made so far
);
	reg [1:0] cnt;

	// The call starts in the cycle a request stands at an instruction end,
	// so a request that stands only one cycle is never half taken
	always @*
	begin
		cpu_take = int_req && cpu_instr_done;
	end

	// A call starts only where an instruction ends, never mid-instruction
	always @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt <= 2'h0;
			cpu_instr_done <= 1'h0;
			last_vec <= 16'h0000;
			takes <= 8'h00;
		end
		else
		begin
			cnt <= cnt + 2'h1;
			cpu_instr_done <= !slow || cnt == 2'h3;
			if (cpu_take)
			begin
				last_vec <= int_vector;
				takes <= takes + 8'h01;
			end
		end
	end
endmodule // tvi_cpu_model

// [tvi_unit_asserts.sv]
// Port-level checks of the interrupt unit
`timescale 1ns/100ps
`include "tvi_defines.vh"
module tvi_unit_asserts
(
	input wire clk, // System clock
	input wire rst_b, // Reset, active low
	input wire wb_cyc_i, // Bus cycle
	input wire wb_stb_i, // Bus strobe
	input wire wb_we_i, // Bus write enable
	input wire [9:0] wb_adr_i, // Bus byte address
	input wire [3:0] wb_sel_i, // Bus byte selects
	input wire [31:0] wb_dat_i, // Write data
	input wire wb_ack_o, // Bus acknowledge
	input wire [31:0] wb_dat_o, // Read data
	input wire cpu_instr_done, // Instruction completed
	input wire cpu_take, // Long call started
	input wire cpu_return_from_interrupt, // Return completed
	input wire int_req, // Request to the CPU
	input wire [4:0] int_src, // Requesting rank
	input wire [15:0] int_vector // Call address
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	// A fresh request gets one acknowledge, one clock long
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	bus_answer_a: assert property (bus_req |=> ack_pulse)
		else $error("bus acknowledge missing or too long");
	idle_bus_a: assert property (!wb_cyc_i |=> !wb_ack_o)
		else $error("acknowledge without a cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("acknowledge without a strobe");
	read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
		else $error("upper read lanes not zero");
	vector_map_a: assert property (int_req |-> int_vector == 16'h0003 + {8'h00, int_src, 3'h0})
		else $error("call address does not match rank");
	rank_range_a: assert property (int_req |-> int_src <= 5'h14 && int_src != 5'h0d)
		else $error("request from a rank with no source");
	take_drop_a: assert property (cpu_take && int_req |=> !int_req)
		else $error("request held after the call");
	return_from_interrupt_gap_a: assert property (cpu_return_from_interrupt ##1 !cpu_instr_done |=> !int_req)
		else $error("request before one more instruction");

	// A write that clears the global enable, landing on its ack edge
	sequence global_clear;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] &&
			wb_adr_i[9:2] == `TVI_IDX_INT_EN && !wb_dat_i[`TVI_GLOBAL_EN_BIT];
	endsequence

	// A request already registered may stand one more cycle, never two
	global_off_a: assert property (global_clear |-> ##2 !int_req)
		else $error("request outlived a global disable");
endmodule // tvi_unit_asserts

bind tvi_unit tvi_unit_asserts tvi_unit_asserts_inst
(
	.clk(clk),
	.rst_b(rst_b),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_ack_o(wb_ack_o),
	.wb_dat_o(wb_dat_o),
	.cpu_instr_done(cpu_instr_done),
	.cpu_take(cpu_take),
	.cpu_return_from_interrupt(cpu_return_from_interrupt),
	.int_req(int_req),
	.int_src(int_src),
	.int_vector(int_vector)
);

// [tb.sv]
// Self-checking bench of the interrupt unit
`timescale 1ns/100ps
module tb;
	logic clk, rst_b, cyc, stb, we, ack, pin0, pin1, return_from_interrupt, slow, req, done, take;
	logic [9:0] adr;
	logic [31:0] wdat, rdat;
	logic [20:0] ev;
	logic [4:0] src;
	logic [15:0] vec, lv;
	logic [7:0] takes, ncall, rb;
	integer failures, checked;

	tvi_unit tvi_unit_inst (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .ext_irq0_pin(pin0), .ext_irq1_pin(pin1), .src_event(ev),
		.cpu_instr_done(done), .cpu_take(take), .cpu_return_from_interrupt(return_from_interrupt), .int_req(req),
		.int_src(src), .int_vector(vec));
	tvi_cpu_model tvi_cpu_model_inst (.clk(clk), .rst_b(rst_b), .slow(slow), .int_req(req),
		.int_vector(vec), .cpu_instr_done(done), .cpu_take(take), .last_vec(lv),
		.takes(takes));

	// Free-running 125 MHz clock
	always #4 clk = ~clk;

	task conclude;
		begin
			$display("Checks %0d, errors %0d", checked, failures);
			if (failures == 0 && checked > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask

	task check(input logic [15:0] got, input logic [15:0] exp);
		begin
			checked = checked + 1;
			if (got !== exp)
				$display("Error at %0t: got %h expected %h", $time, got, exp);
			if (got !== exp)
				failures = failures + 1;
		end
	endtask

	task stall;
		begin
			$display("Error at %0t: wait ran out", $time);
			failures = failures + 1;
			conclude;
		end
	endtask

	// Classic cycle held until ack is sampled, then released for a clock
	task wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
		integer i;
		begin
			@(posedge clk);
			cyc <= 1'h1;
			stb <= 1'h1;
			we <= w;
			adr <= {idx, 2'h0};
			wdat <= {24'h0, d};
			i = 0;
			@(posedge clk);
			while (ack !== 1'h1)
			begin
				i = i + 1;
				if (i > 20)
					stall;
				@(posedge clk);
			end
			rb = rdat[7:0];
			cyc <= 1'h0;
			stb <= 1'h0;
		end
	endtask

	task rd(input logic [7:0] idx, input logic [7:0] exp);
		begin
			wb(1'h0, idx, 8'h00);
			check({8'h00, rb}, {8'h00, exp});
		end
	endtask

	// Waits for the next call and compares its address
	task call(input logic [15:0] v);
		integer i;
		begin
			ncall = ncall + 8'h01;
			i = 0;
			while (takes !== ncall)
			begin
				i = i + 1;
				if (i > 60)
					stall;
				@(posedge clk);
			end
			check(lv, v);
		end
	endtask

	task quiet;
		begin
			repeat (20) @(posedge clk);
			check({8'h00, takes}, {8'h00, ncall});
		end
	endtask

	task ev_pulse(input logic [20:0] m);
		begin
			@(posedge clk);
			ev <= m;
			@(posedge clk);
			ev <= 21'h0;
		end
	endtask

	task ret;
		begin
			@(posedge clk);
			return_from_interrupt <= 1'h1;
			@(posedge clk);
			return_from_interrupt <= 1'h0;
			repeat (3) @(posedge clk);
		end
	endtask

	task t_regs;
		begin
			rd(8'hf0, 8'h00);
			wb(1'h1, 8'hf0, 8'h5a);
			rd(8'hf0, 8'h5a);
			rd(8'hb8, 8'hc0);
			rd(8'h10, 8'h00);
		end
	endtask

	task t_mask;
		begin
			wb(1'h1, 8'ha8, 8'h10);
			ev_pulse(21'h10);
			quiet;
			rd(8'hc0, 8'h01);
			wb(1'h1, 8'ha8, 8'h90);
			call(16'h0023);
			rd(8'hc0, 8'h01);
			wb(1'h1, 8'hc0, 8'h00);
			ret;
			wb(1'h1, 8'hc0, 8'h01);
			call(16'h0023);
			ret;
			call(16'h0023);
			wb(1'h1, 8'hc0, 8'h00);
			ret;
		end
	endtask

	// Slow instructions here hold every call to a four-clock instruction end
	task t_rank;
		begin
			slow <= 1'h1;
			wb(1'h1, 8'ha8, 8'h93);
			ev_pulse(21'h12);
			call(16'h000b);
			rd(8'h88, 8'h00);
			ret;
			call(16'h0023);
			wb(1'h1, 8'hc0, 8'h00);
			ret;
			wb(1'h1, 8'hb8, 8'h10);
			ev_pulse(21'h02);
			call(16'h000b);
			ev_pulse(21'h10);
			call(16'h0023);
			wb(1'h1, 8'hc0, 8'h00);
			ret;
			ret;
			slow <= 1'h0;
		end
	endtask

	task t_ext;
		begin
			wb(1'h1, 8'ha8, 8'h81);
			wb(1'h1, 8'h88, 8'h01);
			pin0 <= 1'h0;
			call(16'h0003);
			rd(8'h88, 8'h01);
			pin0 <= 1'h1;
			ret;
			pin1 <= 1'h0;
			rd(8'h88, 8'h09);
			pin1 <= 1'h1;
			rd(8'h88, 8'h01);
			quiet;
		end
	endtask

	// Global clear lands while a fresh request is registered: one-cycle window
	task t_race;
		begin
			wb(1'h1, 8'ha8, 8'h90);
			fork
				wb(1'h1, 8'ha8, 8'h10);
				ev_pulse(21'h10);
			join
			call(16'h0023);
			rd(8'ha8, 8'h10);
			rd(8'hc3, 8'h80);
			ret;
			quiet;
			wb(1'h1, 8'hc0, 8'h00);
		end
	endtask

	// Extended enables, the self-clearing CAN flag and the last vector
	task t_far;
		begin
			wb(1'h1, 8'he6, 8'hff);
			rd(8'he6, 8'h7f);
			wb(1'h1, 8'he7, 8'h60);
			wb(1'h1, 8'ha8, 8'h80);
			ev_pulse(21'h180000);
			call(16'h009b);
			rd(8'hc1, 8'h00);
			ret;
			call(16'h00a3);
			rd(8'hc2, 8'h01);
			wb(1'h1, 8'hc2, 8'h00);
			ret;
			quiet;
		end
	endtask

	// Reset for five clocks, then the scenarios in turn
	initial
	begin
		clk = 1'h0;
		rst_b = 1'h0;
		{cyc, stb, we, return_from_interrupt, slow} = 5'h00;
		adr = 10'h000;
		wdat = 32'h0;
		{pin0, pin1} = 2'h3;
		ev = 21'h0;
		ncall = 8'h00;
		failures = 0;
		checked = 0;
		repeat (5) @(posedge clk);
		rst_b <= 1'h1;
		t_regs;
		t_mask;
		t_rank;
		t_ext;
		t_race;
		t_far;
		conclude;
	end
endmodule // tb
